// ---- ustep_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - each frame is one 20-bit command, one status
// - one status bit out per clock bit in
// - serial coil current writes, step input disableable
// - step input enabled straight after reset
// - mode bit picks rising or both step edges
// - direction sampled on every active step edge
// - fullstep or 2 to 256 microsteps selectable
// - dir low counts up, high down, by resolution
// - counter drives sine and cosine table
// - off-time or spread chopper selectable
// - mux picks table or serial coil values
module ustep_sequencer (
	// system
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite slave
	input wire logic [3:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [3:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// step and direction pins
	input wire logic step_in,
	input wire logic dir_in,
	// serial command port
	input wire logic sck,
	input wire logic csn,
	input wire logic sdi,
	output logic sdo_out,
	output logic sdo_oe,
	// coil current targets and chopper choice
	output stepper_pkg::coil_t coil,
	output logic chop_sel
);

	// ---------------- serial link domain ----------------
	logic [4:0] bit_cnt_r;
	logic [18:0] rx_r;
	logic [19:0] cmd_hold_r;
	logic done_r;
	logic sdo_r;
	logic [19:0] snap_r;

	always_ff @(posedge sck or posedge csn) begin
		if (csn) begin
			bit_cnt_r <= 5'h00;
			rx_r <= 19'h00000;
			done_r <= 1'b0;
		end else begin
			rx_r <= {rx_r[17:0], sdi};
			if (bit_cnt_r != stepper_pkg::WORD_BITS)
				bit_cnt_r <= bit_cnt_r + 5'h01;
			if (bit_cnt_r == stepper_pkg::WORD_BITS - 5'h01)
				done_r <= 1'b1;
		end
	end

	always_ff @(posedge sck) begin
		if (!csn && bit_cnt_r == stepper_pkg::WORD_BITS - 5'h01)
			cmd_hold_r <= {rx_r, sdi};
	end

	// the top status bit is zero, so it is ready before the first edge
	always_ff @(negedge sck or posedge csn) begin
		if (csn)
			sdo_r <= 1'b0;
		else if (bit_cnt_r < stepper_pkg::WORD_BITS)
			sdo_r <= snap_r[5'h13 - bit_cnt_r];
		else
			sdo_r <= 1'b0;
	end

	assign sdo_out = sdo_r;

	// ---------------- pin synchronisers ----------------
	// bit 0 step, 1 dir, 2 chip select, 3 frame done
	wire [3:0] raw = {done_r, csn, dir_in, step_in};
	logic [3:0] s1_r, s2_r, s3_r, lvl_r;
	wire [3:0] chg;
	wire [3:0] lvl_nxt;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			assign chg[gi] = (s2_r[gi] == s3_r[gi]) &&
				(s3_r[gi] != lvl_r[gi]);
			assign lvl_nxt[gi] = chg[gi] ? s3_r[gi] : lvl_r[gi];
			always_ff @(posedge aclk) begin
				s1_r[gi] <= raw[gi];
				s2_r[gi] <= s1_r[gi];
				s3_r[gi] <= s2_r[gi];
				if (!aresetn)
					lvl_r[gi] <= (gi == 2);
				else
					lvl_r[gi] <= lvl_nxt[gi];
			end
		end
	endgenerate

	// ---------------- control state ----------------
	stepper_pkg::ctrl_t ctrl_r, ctrl_nxt;
	stepper_pkg::coil_t direct_r, direct_nxt;
	stepper_pkg::coil_t coil_r, coil_nxt;
	logic [9:0] ustep_r, ustep_nxt;
	logic chop_r;
	logic oe_r;

	wire cmd_evt = chg[3] && s3_r[3];
	wire [1:0] cmd_code = cmd_hold_r[19:18];
	wire csn_idle = lvl_r[2] && s2_r[2] && s3_r[2];
	wire step_rise = chg[0] && s3_r[0];
	wire step_edge = chg[0] &&
		(s3_r[0] || ctrl_r.both_edge_step_select);
	wire step_evt = step_edge && !ctrl_r.step_dis;
	wire dir_lvl = lvl_r[1];
	wire [3:0] mres_eff = (ctrl_r.mres > stepper_pkg::MRES_FULL) ?
		stepper_pkg::MRES_FULL : ctrl_r.mres;
	wire [9:0] inc = 10'h001 << mres_eff;

	// ---------------- axi4-lite slave ----------------
	logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;
	logic [3:0] waddr_r;

	wire aw_take = awvalid && wvalid && !awready_r && !bvalid_r;
	wire w_fire = awready_r && awvalid && wvalid;
	wire ar_take = arvalid && !arready_r && !rvalid_r;
	wire ar_fire = arready_r && arvalid;
	wire w_ctrl = w_fire && waddr_r == stepper_pkg::CTRL_OFF;
	wire w_direct = w_fire && waddr_r == stepper_pkg::DIRECT_OFF;
	wire w_ok = w_ctrl || w_direct ||
		waddr_r == stepper_pkg::STATUS_OFF ||
		waddr_r == stepper_pkg::COIL_OFF;
	wire r_ok = araddr == stepper_pkg::CTRL_OFF ||
		araddr == stepper_pkg::STATUS_OFF ||
		araddr == stepper_pkg::COIL_OFF ||
		araddr == stepper_pkg::DIRECT_OFF;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				res[i*8 +: 8] = nw[i*8 +: 8];
		return res;
	endfunction

	wire [31:0] direct_word = merge({14'h0000, direct_r}, wdata, wstrb);
	wire [31:0] ctrl_word = merge({24'h000000, ctrl_r}, wdata, wstrb);
	wire [31:0] status_word = {22'h000000, ustep_r};
	wire [31:0] rd_mux =
		(araddr == stepper_pkg::CTRL_OFF) ? {24'h000000, ctrl_r} :
		(araddr == stepper_pkg::STATUS_OFF) ? status_word :
		(araddr == stepper_pkg::COIL_OFF) ? {14'h0000, coil_r} :
		(araddr == stepper_pkg::DIRECT_OFF) ? {14'h0000, direct_r} :
		32'h00000000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= stepper_pkg::RESP_OKAY;
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rresp_r <= stepper_pkg::RESP_OKAY;
			rdata_r <= 32'h00000000;
			waddr_r <= 4'h0;
		end else begin
			awready_r <= aw_take;
			wready_r <= aw_take;
			if (aw_take)
				waddr_r <= awaddr;
			if (w_fire) begin
				bvalid_r <= 1'b1;
				bresp_r <= w_ok ? stepper_pkg::RESP_OKAY :
					stepper_pkg::RESP_SLVERR;
			end else if (bready)
				bvalid_r <= 1'b0;
			arready_r <= ar_take;
			if (ar_fire) begin
				rvalid_r <= 1'b1;
				rdata_r <= rd_mux;
				rresp_r <= r_ok ? stepper_pkg::RESP_OKAY :
					stepper_pkg::RESP_SLVERR;
			end else if (rready)
				rvalid_r <= 1'b0;
		end
	end

	assign awready = awready_r;
	assign wready = wready_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = arready_r;
	assign rvalid = rvalid_r;
	assign rresp = rresp_r;
	assign rdata = rdata_r;

	// ---------------- sine table ----------------
	function automatic logic signed [8:0] sine_of(input logic [9:0] ph);
		logic [8:0] x;
		logic [7:0] lo, hi;
		logic [11:0] mag;
		x = ph[8] ? 9'h100 - {1'b0, ph[7:0]} : {1'b0, ph[7:0]};
		lo = stepper_pkg::SINE_TAB[x[8:4]];
		hi = (x[8:4] == 5'h10) ? lo : stepper_pkg::SINE_TAB[x[8:4] + 5'h01];
		mag = {lo, 4'h0} + 12'(hi - lo) * 12'(x[3:0]);
		return ph[9] ? -$signed({1'b0, mag[11:4]}) :
			$signed({1'b0, mag[11:4]});
	endfunction

	// ---------------- next state ----------------
	always_comb begin
		ctrl_nxt = ctrl_r;
		direct_nxt = direct_r;
		if (cmd_evt && cmd_code == stepper_pkg::CMD_CTRL)
			ctrl_nxt = cmd_hold_r[7:0];
		if (cmd_evt && cmd_code == stepper_pkg::CMD_COIL)
			direct_nxt = cmd_hold_r[17:0];
		if (w_ctrl)
			ctrl_nxt = ctrl_word[7:0];
		if (w_direct)
			direct_nxt = direct_word[17:0];
	end

	// ten bits span four fullsteps, so plain wrap keeps the phase
	assign ustep_nxt = !step_evt ? ustep_r :
		dir_lvl ? ustep_r - inc : ustep_r + inc;

	assign coil_nxt = ctrl_r.direct_mode ? direct_r :
		{sine_of(ustep_r), sine_of(ustep_r + stepper_pkg::QUARTER)};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= stepper_pkg::CTRL_RST;
			direct_r <= stepper_pkg::COIL_RST;
			coil_r <= stepper_pkg::COIL_RST;
			ustep_r <= 10'h000;
			chop_r <= 1'b0;
			oe_r <= 1'b0;
			snap_r <= 20'h00000;
		end else begin
			ctrl_r <= ctrl_nxt;
			direct_r <= direct_nxt;
			coil_r <= coil_nxt;
			ustep_r <= ustep_nxt;
			chop_r <= ctrl_r.chop_sel;
			oe_r <= !lvl_r[2];
			// status word frozen while a frame may be running
			if (csn_idle)
				snap_r <= {1'b0, ustep_r, 1'b0, ctrl_r};
		end
	end

	assign coil = coil_r;
	assign chop_sel = chop_r;
	assign sdo_oe = oe_r;

	// ---------------- assertions ----------------
	a_step_forward: assert property (@(posedge aclk) disable iff (!aresetn)
		step_evt && !dir_lvl |=> ustep_r == $past(ustep_r) + $past(inc))
		else $error("forward step did not add increment");

	a_step_backward: assert property (@(posedge aclk) disable iff (!aresetn)
		step_evt && dir_lvl |=> ustep_r == $past(ustep_r) - $past(inc))
		else $error("backward step did not subtract increment");

	a_falling_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
		chg[0] && !step_rise && !ctrl_r.both_edge_step_select
		|=> $stable(ustep_r))
		else $error("falling step edge moved counter");

	a_reset_step_on: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(aresetn) |-> !ctrl_r.step_dis && ctrl_r.mres == 4'h0)
		else $error("step input not enabled after reset");

	a_full_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
		step_evt && dir_lvl && ustep_r == 10'h000 &&
		mres_eff == stepper_pkg::MRES_FULL |=> ustep_r == 10'h300)
		else $error("counter did not wrap downward");

	a_table_path: assert property (@(posedge aclk) disable iff (!aresetn)
		!ctrl_r.direct_mode |=> coil_r.a == sine_of($past(ustep_r)) &&
		coil_r.b == sine_of($past(ustep_r) + stepper_pkg::QUARTER))
		else $error("coil not from sine table");

	a_direct_path: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl_r.direct_mode |=> coil_r == $past(direct_r))
		else $error("coil not from direct value");

	a_serial_coil: assert property (@(posedge aclk) disable iff (!aresetn)
		cmd_evt && cmd_code == stepper_pkg::CMD_COIL && !w_direct
		|=> direct_r == $past(cmd_hold_r[17:0]))
		else $error("serial coil write lost");

	a_chop_follow: assert property (@(posedge aclk) disable iff (!aresetn)
		chop_r == $past(ctrl_r.chop_sel))
		else $error("chopper select not following control");

	a_frame_length: assert property (@(negedge sck) disable iff (csn)
		done_r == (bit_cnt_r == stepper_pkg::WORD_BITS))
		else $error("frame done flag out of step with bit count");

endmodule

`default_nettype wire

// ---- stepper_pkg.sv ----
`default_nettype none
package stepper_pkg;

	// register byte offsets on the AXI4-Lite port
	localparam logic [3:0] CTRL_OFF = 4'h0;
	localparam logic [3:0] STATUS_OFF = 4'h4;
	localparam logic [3:0] COIL_OFF = 4'h8;
	localparam logic [3:0] DIRECT_OFF = 4'hc;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// control bits, shared by the bus register and the serial command
	typedef struct packed {
		logic chop_sel;
		logic direct_mode;
		logic step_dis;
		logic [3:0] mres;
		logic both_edge_step_select;
	} ctrl_t;

	typedef struct packed {
		logic signed [8:0] a;
		logic signed [8:0] b;
	} coil_t;

	// step input enabled, 256 microsteps, rising edge only, off-time chopper
	localparam ctrl_t CTRL_RST = 8'h00;
	localparam coil_t COIL_RST = 18'h00000;
	localparam logic [3:0] MRES_FULL = 4'h8;

	// serial frame: two code bits on top of the word
	localparam logic [4:0] WORD_BITS = 5'h14;
	localparam logic [1:0] CMD_CTRL = 2'h0;
	localparam logic [1:0] CMD_COIL = 2'h1;

	localparam logic [9:0] QUARTER = 10'h100;

	// quarter sine wave, 17 points, full scale 255
	localparam logic [7:0] SINE_TAB [0:16] = '{
		8'h00, 8'h19, 8'h32, 8'h4a, 8'h62, 8'h78, 8'h8e, 8'ha2, 8'hb4,
		8'hc5, 8'hd4, 8'he1, 8'hec, 8'hf4, 8'hfa, 8'hfe, 8'hff
	};

endpackage

`default_nettype wire

// ---- serial_master.sv ----
`timescale 1ns/1ps
`default_nettype none
module serial_master (
	// serial pins
	output logic sck,
	output logic csn,
	output logic sdi,
	input wire logic sdo
);
	initial begin
		sck = 1'b0;
		csn = 1'b1;
		sdi = 1'b0;
	end
	// clock stands still low outside frames
	task automatic xfer(input logic [19:0] c, output logic [19:0] s);
		csn = 1'b0;
		#150;
		for (int i = 19; i >= 0; i--) begin
			sdi = c[i];
			#3 sck = 1'b1;
			s[i] = sdo;
			#3 sck = 1'b0;
		end
		#150 csn = 1'b1;
		sdi = ~sdi;
		#200;
	endtask
endmodule
`default_nettype wire

// ---- tb_ustep_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_ustep_sequencer;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, step_in = 1'b0, dir_in = 1'b0;
	logic [31:0] wdata = 32'h0, rdata, rd_d;
	logic [1:0] bresp, rresp, rd_r, wr_r;
	logic awready, wready, bvalid, arready, rvalid, sck, csn, sdi;
	logic sdo_out, sdo_oe, chop_sel, both = 1'b0, dis = 1'b0;
	logic [19:0] st;
	logic [7:0] cv = 8'h00;
	stepper_pkg::coil_t coil, dc;
	logic [17:0] dw;
	int n_fail = 0, checks = 0, cyc = 0, ustep = 0, mres = 0;
	int seed = 32'h4ceffa22;
	wire sdo_w = sdo_oe ? sdo_out : ~sdo_out;
	always #12.5 aclk = ~aclk;
	ustep_sequencer i_ustep_sequencer (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .step_in(step_in), .dir_in(dir_in), .sck(sck),
		.csn(csn), .sdi(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
		.coil(coil), .chop_sel(chop_sel));
	serial_master i_serial_master (.sck(sck), .csn(csn), .sdi(sdi),
		.sdo(sdo_w));
	task automatic summarize();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			summarize();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, s);
		checks++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	function automatic logic [17:0] tab(input int q);
		case (q)
			0: return 18'h000ff;
			1: return {9'h0ff, 9'h000};
			2: return 18'h00101;
			default: return {9'h101, 9'h000};
		endcase
	endfunction
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge aclk); while (!awready);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		while (!bvalid) @(posedge aclk);
		wr_r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		rd_d = rdata;
		rd_r = rresp;
		rready <= 1'b0;
	endtask
	task automatic model(input logic [7:0] v);
		cv = v;
		both = v[0];
		mres = (v[4:1] > 4'h8) ? 8 : int'(v[4:1]);
		dis = v[5];
	endtask
	task automatic setc(input logic [7:0] v);
		wr(stepper_pkg::CTRL_OFF, {24'h0, v});
		chk("bresp", stepper_pkg::RESP_OKAY, wr_r);
		model(v);
	endtask
	task automatic stp(input logic d, input logic l);
		@(posedge aclk);
		dir_in <= d;
		repeat (5) @(posedge aclk);
		if (l != step_in && !dis && (l || both))
			ustep = (ustep + (d ? -(1 << mres) : (1 << mres))) & 1023;
		step_in <= l;
		repeat (8) @(posedge aclk);
		rd(stepper_pkg::STATUS_OFF);
		chk("ustep", ustep, rd_d);
	endtask
	task automatic frame(input logic [19:0] c);
		i_serial_master.xfer(c, st);
		chk("status", {13'h0, ustep[9:0], 1'b0, cv},
			{12'h0, st});
		if (c[19:18] == stepper_pkg::CMD_CTRL)
			model(c[7:0]);
		repeat (6) @(posedge aclk);
	endtask
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		wr(4'h2, 32'h000000ff);
		chk("bresp", stepper_pkg::RESP_SLVERR, wr_r);
		rd(stepper_pkg::CTRL_OFF);
		chk("ctrl", 32'h0, rd_d);
		rd(4'h2);
		chk("rresp", stepper_pkg::RESP_SLVERR, rd_r);
		chk("rdata", 32'h0, rd_d);
		stp(1'b0, 1'b1);
		stp(1'b1, 1'b0);
		stp(1'b1, 1'b1);
		stp(1'b0, 1'b0);
		stp(1'b1, 1'b1);
		stp(1'b0, 1'b0);
		stp(1'b0, 1'b1);
		setc(8'h10);
		stp(1'b0, 1'b0);
		stp(1'b0, 1'b1);
		chk("coil", tab(1), coil);
		setc(8'h11);
		stp(1'b1, 1'b0);
		stp(1'b1, 1'b1);
		chk("coil", tab(3), coil);
		frame({stepper_pkg::CMD_CTRL, 10'h0, 8'he1});
		rd(stepper_pkg::CTRL_OFF);
		chk("ctrl", 32'he1, rd_d);
		stp(1'b1, 1'b0);
		dc = 18'($random(seed));
		frame({stepper_pkg::CMD_COIL, dc});
		chk("coil", dc, coil);
		chk("chop", 1'b1, chop_sel);
		dw = 18'($random(seed));
		wr(stepper_pkg::DIRECT_OFF, {14'h0, dw});
		chk("bresp", stepper_pkg::RESP_OKAY, wr_r);
		repeat (2) @(posedge aclk);
		chk("coil", dw, coil);
		setc(8'h00);
		repeat (4) @(posedge aclk);
		chk("coil", tab(3), coil);
		chk("chop", 1'b0, chop_sel);
		for (int m = 0; m < 10; m++) begin
			setc({3'h0, m[3:0], 1'($random(seed))});
			stp(1'($random(seed)), ~step_in);
		end
		frame(20'h0);
		summarize();
	end
endmodule
`default_nettype wire
